// ### verilog/polled_io_status_bank.sv
// Polled I/O status bank: byte-wide read-only status words plus
// interrupt status and mask, reached over classic Wishbone.
// Assumes all inputs come from logic on clk_i.
// Functional notes
// - Location 127: running slot, read/write slot
// - Locations 128-131: per-pin trigger flags
// - Location 132 low nibble: polling mode value
// - Location 133 low bits: event run slot
// - Location 134 bit0: active I/O group
// - Status bit0: polled outputs enabled
// - Status bit1: some polled input defined
// - Status bit2: polled run enabled
// - Status bit3: real-time or latch output mode
// - Status bit4: a polled input triggered
// - Status bit5: an output signal latched
// - Status bit6: wait event, cleared by mode command
// - Status bit7: polling active
// - Flags persist; clearing also stops polling
`timescale 1ns/10ps
module polled_io_status_bank (
   input  wire logic                            clk_i,         // 20 MHz clock
   input  wire logic                            rst_i,         // Sync reset, high
   input  wire logic                            wb_cyc_i,      // Bus cycle
   input  wire logic                            wb_stb_i,      // Strobe
   input  wire logic                            wb_we_i,       // Write enable
   input  wire logic [3:0]                      wb_sel_i,      // Byte enables
   input  wire logic [31:0]                     wb_adr_i,      // Byte address
   input  wire logic [31:0]                     wb_dat_i,      // Write data
   output logic      [31:0]                     wb_dat_o,      // Read data
   output logic                                 wb_ack_o,      // Acknowledge
   input  wire logic [3:0]                      run_slot_i,    // Running slot
   input  wire logic [3:0]                      rw_slot_i,     // Read/write slot
   input  wire logic [poll_status_pkg::PIN_W-1:0] pin_trig_i,  // Per-pin trigger pulses
   input  wire logic                            io_group_i,    // 1 = auxiliary group
   input  wire logic                            in_defined_i,  // Polled input defined
   input  wire logic                            wait_evt_i,    // Poll-wait event pulse
   input  wire poll_status_pkg::mode_cmd_t      mode_cmd_i,    // Polling mode command
   input  wire poll_status_pkg::run_cmd_t       run_cmd_i,     // Event slot select
   output logic                                 active_o,      // Polling active
   output logic                                 irq_o          // Interrupt, level
);

   poll_status_pkg::bank_state_t st_ff;
   poll_status_pkg::bank_state_t nxt_st;

   logic [7:0] idx;
   logic       req;
   logic       wr_lane;
   logic [poll_status_pkg::PIN_W-1:0] hit;
   logic [7:0] status_byte;
   logic [7:0] rd_byte;
   logic [poll_status_pkg::IRQ_W-1:0] irq_set;
   logic [poll_status_pkg::IRQ_W-1:0] irq_clr;
   logic [poll_status_pkg::IRQ_W-1:0] irq_nxt;
   logic [poll_status_pkg::IRQ_W-1:0] irq_pend;
   logic [poll_status_pkg::PIN_W-1:0] flag_nxt;
   logic [3:0][7:0]                   flag_byte;
   logic                              take;
   logic                              clr_cmd;
   logic                              stat_wr;
   logic                              mask_wr;

   assign idx     = wb_adr_i[poll_status_pkg::ADR_MSB:poll_status_pkg::ADR_LSB];
   assign req     = wb_cyc_i & wb_stb_i;
   // Write lands at the edge where ack is seen high
   assign wr_lane = req & wb_we_i & st_ff.ack & wb_sel_i[0];
   // Triggers only count while polling runs
   assign hit     = pin_trig_i & {poll_status_pkg::PIN_W{st_ff.active}};

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   // Taken once; the request held through ack is not taken again
   assign take    = req & ~st_ff.ack;
   assign stat_wr = wr_lane & (idx == poll_status_pkg::IDX_IRQ_STATUS);
   assign mask_wr = wr_lane & (idx == poll_status_pkg::IDX_IRQ_MASK);
   assign clr_cmd = mode_cmd_i.valid & mode_cmd_i.clear;

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin trigger flags
   // sticky flags, clear stops polling
   // A trigger in the clear cycle survives, so no event is lost
   for (genvar g = 0; g < poll_status_pkg::PIN_W; g++) begin : g_pin
      assign flag_nxt[g] = clr_cmd ? hit[g] : (st_ff.flags[g] | hit[g]);
   end

   for (genvar b = 0; b < 4; b++) begin : g_byte
      assign flag_byte[b] = st_ff.flags[8*b +: 8];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt bits
   assign irq_set[poll_status_pkg::IRQ_TRIG] = |hit;
   assign irq_set[poll_status_pkg::IRQ_WAIT] = wait_evt_i;
   assign irq_clr = stat_wr ? wb_dat_i[poll_status_pkg::IRQ_W-1:0] : poll_status_pkg::IRQ_RST;
   // Set beats write-one-to-clear
   for (genvar k = 0; k < poll_status_pkg::IRQ_W; k++) begin : g_irq
      assign irq_nxt[k]  = (st_ff.irq_stat[k] & ~irq_clr[k]) | irq_set[k];
      assign irq_pend[k] = st_ff.irq_stat[k] & st_ff.irq_mask[k];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read view
   always_comb begin
      status_byte = 8'h00;
      status_byte[poll_status_pkg::ST_OUT_EN]   = st_ff.out_en;
      status_byte[poll_status_pkg::ST_IN_DEF]   = in_defined_i;
      status_byte[poll_status_pkg::ST_RUN_EN]   = st_ff.run_en;
      status_byte[poll_status_pkg::ST_LATCH_MD] = st_ff.latch_mode;
      status_byte[poll_status_pkg::ST_TRIG]     = |st_ff.flags;
      status_byte[poll_status_pkg::ST_LATCHED]  = st_ff.latched;
      status_byte[poll_status_pkg::ST_WAIT]     = st_ff.wait_evt;
      status_byte[poll_status_pkg::ST_ACTIVE]   = st_ff.active;
   end

   always_comb begin
      case (idx)
         poll_status_pkg::IDX_SLOT_SELECT: rd_byte = {rw_slot_i, run_slot_i};
         poll_status_pkg::IDX_MAIN_LOW:    rd_byte = flag_byte[0];
         poll_status_pkg::IDX_MAIN_HIGH:   rd_byte = flag_byte[1];
         poll_status_pkg::IDX_AUX_LOW:     rd_byte = flag_byte[2];
         poll_status_pkg::IDX_AUX_HIGH:    rd_byte = flag_byte[3];
         poll_status_pkg::IDX_MODE_VALUE:  rd_byte = {4'h0, st_ff.mode};
         poll_status_pkg::IDX_RUN_SLOT:    rd_byte = {5'h00, st_ff.run_slot};
         poll_status_pkg::IDX_IO_GROUP:    rd_byte = {7'h00, io_group_i};
         poll_status_pkg::IDX_STATUS:      rd_byte = status_byte;
         poll_status_pkg::IDX_IRQ_STATUS:  rd_byte = {6'h00, st_ff.irq_stat};
         poll_status_pkg::IDX_IRQ_MASK:    rd_byte = {6'h00, st_ff.irq_mask};
         default:                          rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_st = st_ff;

      // Ack one cycle, dropped the next
      nxt_st.ack = take;
      if (take) begin
         nxt_st.dat = rd_byte;
      end

      nxt_st.flags = flag_nxt;
      if (clr_cmd) begin
         nxt_st.latched = 1'b0;
         nxt_st.active  = 1'b0;
      end

      if (mode_cmd_i.valid) begin
         nxt_st.mode       = mode_cmd_i.mode;
         nxt_st.out_en     = mode_cmd_i.out_en;
         nxt_st.run_en     = mode_cmd_i.run_en;
         nxt_st.latch_mode = mode_cmd_i.latch_mode;
         if (~mode_cmd_i.clear) begin
            nxt_st.active = mode_cmd_i.out_en | mode_cmd_i.run_en;
         end
         nxt_st.wait_evt = 1'b0;
      end
      if (wait_evt_i) begin
         nxt_st.wait_evt = 1'b1;
      end

      // latch on trigger in latch mode
      if ((|hit) & st_ff.out_en & st_ff.latch_mode) begin
         nxt_st.latched = 1'b1;
      end

      if (run_cmd_i.valid) begin
         nxt_st.run_slot = run_cmd_i.slot;
      end

      if (mask_wr) begin
         nxt_st.irq_mask = wb_dat_i[poll_status_pkg::IRQ_W-1:0];
      end
      nxt_st.irq_stat = irq_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff.flags      <= poll_status_pkg::FLAGS_RST;
         st_ff.mode       <= poll_status_pkg::MODE_RST;
         st_ff.run_slot   <= poll_status_pkg::RSLOT_RST;
         st_ff.out_en     <= 1'b0;
         st_ff.run_en     <= 1'b0;
         st_ff.latch_mode <= 1'b0;
         st_ff.latched    <= 1'b0;
         st_ff.wait_evt   <= 1'b0;
         st_ff.active     <= 1'b0;
         st_ff.irq_stat   <= poll_status_pkg::IRQ_RST;
         st_ff.irq_mask   <= poll_status_pkg::IRQ_RST;
         st_ff.ack        <= 1'b0;
         st_ff.dat        <= poll_status_pkg::BYTE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = {24'h00_0000, st_ff.dat};
   assign active_o = st_ff.active;
   assign irq_o    = |irq_pend;

endmodule : polled_io_status_bank

// ### verilog/poll_status_pkg.sv
// Constants and carrier types for the polled I/O status bank.
// Assumes a 32-bit classic Wishbone slave, one aligned word per register.
package poll_status_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SLOT_SELECT = 8'h7f;
   localparam logic [7:0] IDX_MAIN_LOW    = 8'h80;
   localparam logic [7:0] IDX_MAIN_HIGH   = 8'h81;
   localparam logic [7:0] IDX_AUX_LOW     = 8'h82;
   localparam logic [7:0] IDX_AUX_HIGH    = 8'h83;
   localparam logic [7:0] IDX_MODE_VALUE  = 8'h84;
   localparam logic [7:0] IDX_RUN_SLOT    = 8'h85;
   localparam logic [7:0] IDX_IO_GROUP    = 8'h86;
   localparam logic [7:0] IDX_STATUS      = 8'h87;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h88;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h89;
   localparam int         ADR_LSB         = 2;
   localparam int         ADR_MSB         = 9;

   // Status byte field positions
   localparam int ST_OUT_EN   = 0;
   localparam int ST_IN_DEF   = 1;
   localparam int ST_RUN_EN   = 2;
   localparam int ST_LATCH_MD = 3;
   localparam int ST_TRIG     = 4;
   localparam int ST_LATCHED  = 5;
   localparam int ST_WAIT     = 6;
   localparam int ST_ACTIVE   = 7;

   // Interrupt bit positions
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_WAIT = 1;
   localparam int IRQ_W    = 2;

   localparam int PIN_W = 32;

   localparam logic [PIN_W-1:0] FLAGS_RST = 32'h0000_0000;
   localparam logic [3:0]       MODE_RST  = 4'h0;
   localparam logic [2:0]       RSLOT_RST = 3'h0;
   localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;
   localparam logic [7:0]       BYTE_RST  = 8'h00;

   // Polling mode command from the interpreter
   typedef struct packed {
      logic       valid;       // One-cycle strobe
      logic [3:0] mode;        // Mode value to report
      logic       out_en;      // Polled outputs enable
      logic       run_en;      // Polled run enable
      logic       latch_mode;  // 1 = outputs latch
      logic       clear;       // Clear flags, stop polling
   } mode_cmd_t;

   // Event slot select command
   typedef struct packed {
      logic       valid;
      logic [2:0] slot;
   } run_cmd_t;

   typedef struct packed {
      logic [PIN_W-1:0] flags;
      logic [3:0]       mode;
      logic [2:0]       run_slot;
      logic             out_en;
      logic             run_en;
      logic             latch_mode;
      logic             latched;
      logic             wait_evt;
      logic             active;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic             ack;
      logic [7:0]       dat;
   } bank_state_t;
endpackage : poll_status_pkg

// ### dv/polled_io_status_bank_monitor.sv
// Checker for the polled I/O status bank, bound to its top module.
// Assumes synchronous reset on rst_i and one clock.
`timescale 1ns/10ps
module polled_io_status_bank_monitor (
   input wire logic                       clk_i,      // Clock
   input wire logic                       rst_i,      // Reset
   input wire logic                       wb_cyc_i,   // Cycle
   input wire logic                       wb_stb_i,   // Strobe
   input wire logic                       wb_we_i,    // Write
   input wire logic [31:0]                wb_adr_i,   // Address
   input wire logic [31:0]                wb_dat_o,   // Read data
   input wire logic                       wb_ack_o,   // Ack
   input wire logic [3:0]                 run_slot_i, // Running slot
   input wire logic [3:0]                 rw_slot_i,  // R/W slot
   input wire poll_status_pkg::mode_cmd_t mode_cmd_i, // Mode command
   input wire logic                       active_o,   // Active
   input wire logic                       irq_o       // Interrupt
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rd_slot_s;
      req_s ##0 (!wb_we_i && wb_adr_i[9:2] == poll_status_pkg::IDX_SLOT_SELECT);
   endsequence
   ack_after_req_a: assert property (req_s |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   slot_read_a: assert property (rd_slot_s |=>
      wb_dat_o[7:4] == $past(rw_slot_i) && wb_dat_o[3:0] == $past(run_slot_i))
      else $error("slot byte wrong");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   dat_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
      else $error("read data moved without request");
   clear_stops_a: assert property (mode_cmd_i.valid && mode_cmd_i.clear |=> !active_o)
      else $error("clear left polling on");
   active_set_a: assert property (mode_cmd_i.valid && !mode_cmd_i.clear &&
      (mode_cmd_i.out_en || mode_cmd_i.run_en) |=> active_o) else $error("not active");
   active_hold_a: assert property (!mode_cmd_i.valid |=> $stable(active_o))
      else $error("active moved without command");
   irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("irq dropped without write");
endmodule : polled_io_status_bank_monitor
bind polled_io_status_bank polled_io_status_bank_monitor i_polled_io_status_bank_monitor (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .run_slot_i, .rw_slot_i, .mode_cmd_i, .active_o, .irq_o);

// ### dv/test_polled_io_status_bank.sv
// Self-checking bench for the polled I/O status bank.
// Assumes the design and its bound checker are compiled first.
`timescale 1ns/10ps
module test_polled_io_status_bank;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, grp = 1'b0, indef = 1'b0;
   logic wevt = 1'b0, e_out = 1'b0, e_run = 1'b0, e_lm = 1'b0, e_latd = 1'b0;
   logic e_wait = 1'b0, e_act = 1'b0;
   logic [3:0]  run_s = 4'h0, rw_s = 4'h0;
   logic [31:0] adr = 32'h0, wdat = 32'h0, trig = 32'h0, e_flags = 32'h0, rdat;
   logic [31:0] seed = 32'h0001_75ee;
   poll_status_pkg::mode_cmd_t mcmd = '0;
   poll_status_pkg::run_cmd_t  rcmd = '0;
   wire logic [31:0] dat_o;
   wire logic        ack_o, act_o, irq;
   int n_errors = 0, checks_done = 0;
   always #25 clk_i = ~clk_i;
   polled_io_status_bank i_polled_io_status_bank (.clk_i, .rst_i, .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack_o), .run_slot_i(run_s), .rw_slot_i(rw_s),
      .pin_trig_i(trig), .io_group_i(grp), .in_defined_i(indef), .wait_evt_i(wevt),
      .mode_cmd_i(mcmd), .run_cmd_i(rcmd), .active_o(act_o), .irq_o(irq));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [31:0] exp_stat();
      return {24'h0, e_act, e_wait, e_latd, |e_flags, e_lm, e_run, indef, e_out};
   endfunction : exp_stat
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Held until ack is sampled high; only the watchdog ends a lost wait
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, we, adr, wdat} <= {1'b1, w, 22'h0, idx, 2'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
   endtask : bus
   task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      check(what, rdat, exp);
   endtask : rd
   task automatic mode(input logic [3:0] m, input logic oe, re, lm, cl);
      @(posedge clk_i);
      mcmd <= {1'b1, m, oe, re, lm, cl};
      @(posedge clk_i);
      mcmd.valid <= 1'b0;
      {e_out, e_run, e_lm, e_wait, e_act} = {oe, re, lm, 1'b0, (oe | re) & ~cl};
      if (cl) {e_flags, e_latd} = '0;
   endtask : mode
   // Triggers count only while polling is active
   task automatic pulse(input logic [31:0] p, input logic w);
      @(posedge clk_i);
      {trig, wevt} <= {p, w};
      @(posedge clk_i);
      {trig, wevt} <= '0;
      if (e_act) e_flags |= p;
      e_latd |= e_act & e_out & e_lm & (|p);
      e_wait |= w;
   endtask : pulse
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int i;
      logic [31:0] r;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 8'h80; i <= 8'h8a; i++) rd("reset", i[7:0], 32'h0);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         r = xs();
         @(posedge clk_i);
         {rw_s, run_s, grp, indef, rcmd} <= {r[7:0], r[8], r[9], 1'b1, r[12:10]};
         @(posedge clk_i);
         rcmd.valid <= 1'b0;
         rd("slot", poll_status_pkg::IDX_SLOT_SELECT, {24'h0, r[7:0]});
         rd("run slot", poll_status_pkg::IDX_RUN_SLOT, {29'h0, r[12:10]});
         rd("group", poll_status_pkg::IDX_IO_GROUP, {31'h0, r[8]});
         rd("status", poll_status_pkg::IDX_STATUS, exp_stat());
      end
      $display("test slots done");
      for (i = 0; i < 16; i++) begin
         r = xs();
         mode(i[3:0], r[0], r[1], r[2], 1'b0);
         rd("mode", poll_status_pkg::IDX_MODE_VALUE, {28'h0, i[3:0]});
         rd("status", poll_status_pkg::IDX_STATUS, exp_stat());
      end
      $display("test modes done");
      mode(4'ha, 1'b1, 1'b0, 1'b1, 1'b0);
      bus(1'b1, poll_status_pkg::IDX_IRQ_MASK, 32'h2);
      pulse(xs() | 32'h0001_8000, 1'b0);
      for (i = 0; i < 4; i++)
         rd("flags", poll_status_pkg::IDX_MAIN_LOW + i[7:0], e_flags[8*i +: 8]);
      rd("status", poll_status_pkg::IDX_STATUS, exp_stat());
      check("irq masked", {31'h0, irq}, 32'h0);
      bus(1'b1, poll_status_pkg::IDX_IRQ_MASK, 32'h3);
      @(negedge clk_i);
      check("irq", {31'h0, irq}, 32'h1);
      rd("irq mask", poll_status_pkg::IDX_IRQ_MASK, 32'h3);
      rd("irq status", poll_status_pkg::IDX_IRQ_STATUS, 32'h1);
      bus(1'b1, poll_status_pkg::IDX_IRQ_STATUS, 32'h1);
      @(negedge clk_i);
      check("irq cleared", {31'h0, irq}, 32'h0);
      rd("flags kept", poll_status_pkg::IDX_MAIN_HIGH, e_flags[15:8]);
      $display("test triggers done");
      pulse(32'h0, 1'b1);
      bus(1'b1, poll_status_pkg::IDX_IRQ_STATUS, 32'h2);
      bus(1'b1, poll_status_pkg::IDX_STATUS, 32'h0);
      rd("wait kept", poll_status_pkg::IDX_STATUS, exp_stat());
      mode(4'h3, 1'b1, 1'b1, 1'b0, 1'b1);
      rd("cleared", poll_status_pkg::IDX_STATUS, exp_stat());
      rd("flags zero", poll_status_pkg::IDX_AUX_HIGH, 32'h0);
      check("active", {31'h0, act_o}, 32'h0);
      $display("test wait and clear done");
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      tally_and_finish();
   end
endmodule : test_polled_io_status_bank
